// ==== hw/trip_supervisor_consts.svh ====
// Constants for the drive trip supervisor: register offsets, field
// positions, reset values, trip codes and timing counts.
// Assumes the clock runs at 25 MHz and offsets are Wishbone byte addresses.
`ifndef TRIP_SUPERVISOR_CONSTS_SVH
`define TRIP_SUPERVISOR_CONSTS_SVH

`define CLK_HZ              25000000
`define TICK_US             1000
`define TICK_CYCLES         (`CLK_HZ / 1000000 * `TICK_US)

`define OFS_CTRL            8'h00
`define OFS_BRAKE_WAIT      8'h04
`define OFS_MAXFREQ         8'h08
`define OFS_OVERSPEED       8'h0C
`define OFS_FWD_LIMIT       8'h10
`define OFS_REV_LIMIT       8'h14
`define OFS_TRIP            8'h18
`define OFS_STATUS          8'h1C
`define OFS_IRQ_STATUS      8'h20
`define OFS_IRQ_ENABLE      8'h24
`define OFS_IRQ_CLEAR       8'h28
`define OFS_RESET_CMD       8'h2C

// Control register fields
`define CTRL_BRAKE_SEL_LSB  0
`define CTRL_TIMEOUT_TRIP   2
`define CTRL_FWD_FORBID     3
`define CTRL_REV_FORBID     4
`define CTRL_POS_MODE       5
`define CTRL_ABS_MODE       6
`define CTRL_RETRY_EN       7
`define CTRL_RESET          32'h0000_0000

`define BRAKE_SEL_ON        2'h1
`define POS_DEV_LIMIT       32'd1000000
`define LOW_SPEED_CHZ       16'd20

// Trip codes: tens digit and units digit, shown as Exx
`define CODE_NONE           8'h00
`define CODE_EMERGENCY      8'h37
`define CODE_BRAKE          8'h38
`define CODE_LOW_OVERLOAD   8'h39
`define CODE_LINK           8'h41
`define CODE_OPT1_BASE      8'h60
`define CODE_OPT2_BASE      8'h70
`define CODE_ENC_OPEN_OFS   8'h00
`define CODE_OVERSPEED_OFS  8'h01
`define CODE_POS_DEV_OFS    8'h02
`define CODE_POS_RANGE_OFS  8'h03
`define CODE_ENC_BOARD_OFS  8'h09

`endif

// ==== hw/trip_supervisor_pkg.sv ====
// Types shared by the drive trip supervisor.
// Assumes the constants header is compiled alongside.
package trip_supervisor_pkg;

	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} wb_req_t;

	typedef struct packed {
		logic        enc_open;
		logic        enc_board_fail;
		logic        opt_fault;
		logic [3:0]  opt_code;
	} port_fault_t;

	typedef struct packed {
		logic        undervoltage;
		logic        power_shutoff;
		logic        retry_standby;
		logic        run_limited;
		logic        panel_comm_err;
	} indication_t;

	typedef enum logic [1:0] {
		BRAKE_IDLE,
		BRAKE_WAIT,
		BRAKE_DONE
	} brake_state_t;

endpackage : trip_supervisor_pkg

// ==== hw/drive_trip_supervisor.sv ====
// Drive trip supervisor: latches the first trip, forces the power output
// off, holds a trip code and gates which reset source may clear it.
// Assumes a 25 MHz clock, a Wishbone classic master and pins from outside.
// Operation
// (R1) Brake select 01: trip when feedback misses the confirm wait time.
// (R2) Emergency enable on and stop input on: output off, emergency trip.
// (R3) Emergency trip clears only from the reset terminal, not the panel.
// (R4) Power-cycle-only trips ignore terminal and key; clear at power-up.
// (R5) Overload at or below 0.2 Hz runs second thermal model and trips.
// (R6) Serial link timeout with trip action selected raises link trip.
// (R7) Option port one faults coded from E60, port two from E70.
// (R8) Supply drop or momentary loss shows undervoltage standby.
// (R9) Failed operator panel exchange shows a communication error.
// (R10) Retry enabled and waiting to restart shows retry standby.
// (R11) Run command for a forbidden direction flags limited run.
// (R12) Open or faulty encoder wiring trips with encoder disconnection.
// (R13) Speed above max frequency times overspeed level trips.
// (R14) Position deviation above 1,000,000 pulses trips in position mode.
// (R15) Absolute mode position beyond forward or reverse limit trips.
// (R16) Encoder board mounting or connection failure trips.
// (R17) Supply shutoff shows a power shutoff indication.
// (R18) A trip latches output off and code until permitted reset.
`include "trip_supervisor_consts.svh"

module drive_trip_supervisor #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int OVL_LIMIT   = 100
) (
	input  wire logic                             clk_i,          // 25 MHz
	input  wire logic                             rst_i,          // Power-up
	input  wire trip_supervisor_pkg::wb_req_t     wb_i,           // Bus req
	output      logic [31:0]                      wb_dat_o,       // Read data
	output      logic                             wb_ack_o,       // Ack
	output      logic                             irq_o,          // Interrupt
	input  wire logic                             emergency_stop_input_i,
	input  wire logic                             emergency_enable_switch_i,
	input  wire logic                             fault_reset_terminal_i,
	input  wire logic                             brake_release_i, // Ours
	input  wire logic                             brake_feedback_i,
	input  wire logic                             overload_i,     // Detector
	input  wire logic [15:0]                      out_freq_i,     // 0.01 Hz
	input  wire logic                             link_timeout_i, // Pulse
	input  wire logic                             panel_fail_i,   // Level
	input  wire logic                             panel_reset_i,  // Key pulse
	input  wire logic                             undervolt_i,    // Level
	input  wire logic                             supply_off_i,   // Level
	input  wire logic                             retry_wait_i,   // Level
	input  wire logic                             run_fwd_i,      // Run cmd
	input  wire logic                             run_rev_i,      // Run cmd
	input  wire trip_supervisor_pkg::port_fault_t option_port_one_i,
	input  wire trip_supervisor_pkg::port_fault_t option_port_two_i,
	input  wire logic [31:0]                      speed_i,        // Measured
	input  wire logic signed [31:0]               pos_i,          // Position
	input  wire logic signed [31:0]               pos_ref_i,      // Reference
	output      logic                             power_enable_o, // Gate
	output      logic [7:0]                       trip_code_o,    // Exx code
	output      trip_supervisor_pkg::indication_t indication_o    // Status
);
	import trip_supervisor_pkg::*;

	// Pin synchronisers: three stages, change accepted when 2 and 3 agree
	// A one-cycle pulse never reaches pin_reg, which rides out bounce
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] pins;
	logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
	assign pins = {emergency_stop_input_i, emergency_enable_switch_i,
		fault_reset_terminal_i, brake_feedback_i, undervolt_i, supply_off_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			pin_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < NSYNC; i++) begin
				if (s2_reg[i] == s3_reg[i])
					pin_reg[i] <= s3_reg[i];
			end
		end
	end

	logic emergency_stop_input, emr_en, rst_term, brake_fb, uv, poff;
	assign {emergency_stop_input, emr_en, rst_term, brake_fb, uv, poff} = pin_reg;

	// Registers
	// Partial writes to stored registers are acked but ignored: only writes with all four byte selects are stored
	logic [31:0] ctrl_reg, brake_wait_reg, maxfreq_reg, overspeed_reg;
	logic signed [31:0] fwd_limit_reg, rev_limit_reg;
	logic [7:0]  irq_status_reg, irq_enable_reg;
	logic        sw_reset_pulse;
	logic        bus_hit;
	assign bus_hit = wb_i.cyc && wb_i.stb && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg       <= `CTRL_RESET;
			brake_wait_reg <= '0;
			maxfreq_reg    <= '0;
			overspeed_reg  <= '0;
			fwd_limit_reg  <= '0;
			rev_limit_reg  <= '0;
			irq_enable_reg <= '0;
		end else if (bus_hit && wb_i.we && wb_i.sel == 4'hF) begin
			unique case (wb_i.adr)
				`OFS_CTRL:       ctrl_reg       <= wb_i.dat;
				`OFS_BRAKE_WAIT: brake_wait_reg <= wb_i.dat;
				`OFS_MAXFREQ:    maxfreq_reg    <= wb_i.dat;
				`OFS_OVERSPEED:  overspeed_reg  <= wb_i.dat;
				`OFS_FWD_LIMIT:  fwd_limit_reg  <= wb_i.dat;
				`OFS_REV_LIMIT:  rev_limit_reg  <= wb_i.dat;
				`OFS_IRQ_ENABLE: irq_enable_reg <= wb_i.dat[7:0];
				default: ;
			endcase
		end
	end

	// Software reset counts as a panel reset request
	assign sw_reset_pulse = bus_hit && wb_i.we && wb_i.adr == `OFS_RESET_CMD
		&& wb_i.dat[0];

	// Millisecond tick for the brake wait time
	// One shared enable pulse, so every timer stays on the single clock
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
	logic tick;
	assign tick = tick_cnt_reg == '0;
	always_ff @(posedge clk_i) begin
		if (rst_i || tick)
			tick_cnt_reg <= ($bits(tick_cnt_reg))'(TICK_CYCLES - 1);
		else
			tick_cnt_reg <= tick_cnt_reg - 1'b1;
	end

	// Brake confirmation timer
	// Confirmation sends it back to idle, so the wait restarts afresh;
	// done holds until release is withdrawn, giving one trip per miss
	brake_state_t brake_reg;
	logic [31:0]  brake_cnt_reg;
	logic         brake_err;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brake_reg     <= BRAKE_IDLE;
			brake_cnt_reg <= '0;
		end else begin
			unique case (brake_reg)
				BRAKE_IDLE: if (brake_release_i &&
					ctrl_reg[`CTRL_BRAKE_SEL_LSB +: 2] == `BRAKE_SEL_ON) begin
					brake_reg     <= BRAKE_WAIT;
					brake_cnt_reg <= brake_wait_reg;
				end
				BRAKE_WAIT: if (brake_fb || !brake_release_i)
					brake_reg <= BRAKE_IDLE;
				else if (brake_cnt_reg == '0)
					brake_reg <= BRAKE_DONE;
				else if (tick)
					brake_cnt_reg <= brake_cnt_reg - 1'b1;
				BRAKE_DONE: if (!brake_release_i)
					brake_reg <= BRAKE_IDLE;
			endcase
		end
	end
	assign brake_err = brake_reg == BRAKE_WAIT && !brake_fb
		&& brake_cnt_reg == '0; // R1

	// Second thermal model: integrates low speed overload
	// Leaky count: cools at the heating rate when the overload goes away,
	// and saturates so a long overload cannot wrap to a low count
	logic [15:0] ovl_acc_reg;
	logic        low_ovl_trip;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ovl_acc_reg <= '0;
		else if (overload_i && out_freq_i <= `LOW_SPEED_CHZ) begin // R5
			if (tick && ovl_acc_reg != 16'hFFFF)
				ovl_acc_reg <= ovl_acc_reg + 16'h1;
		end else if (tick && ovl_acc_reg != '0)
			ovl_acc_reg <= ovl_acc_reg - 16'h1;
	end
	assign low_ovl_trip = ovl_acc_reg >= 16'(OVL_LIMIT); // R5

	// Encoder speed and position checks for one option port
	// The limit product is 64 bits, so no pair of settings overflows it;
	// a deviation beyond the signed 32-bit range is still exact in unsigned pos_dev
	logic [63:0] speed_limit;
	logic [31:0] pos_dev;
	logic        overspeed, pos_dev_err, pos_range_err;
	assign speed_limit = maxfreq_reg * overspeed_reg;
	assign overspeed   = 64'(speed_i) * 64'd100 > speed_limit; // R13
	assign pos_dev     = 32'(pos_i >= pos_ref_i ? pos_i - pos_ref_i
		: pos_ref_i - pos_i);
	assign pos_dev_err = ctrl_reg[`CTRL_POS_MODE]
		&& pos_dev > `POS_DEV_LIMIT; // R14
	assign pos_range_err = ctrl_reg[`CTRL_ABS_MODE]
		&& (pos_i > fwd_limit_reg || pos_i < rev_limit_reg); // R15

	// Code for a port's fault, bit 8 clear means none
	// Board failure outranks the rest: without the board, no other code
	// from that port can be trusted
	function automatic logic [8:0] port_code(input port_fault_t p,
		input logic [7:0] base, input logic enc_checks);
		logic [8:0] r;
		r = '0;
		if (p.enc_board_fail)
			r = {1'b1, base + `CODE_ENC_BOARD_OFS}; // R16
		else if (p.enc_open)
			r = {1'b1, base + `CODE_ENC_OPEN_OFS}; // R12
		else if (enc_checks && overspeed)
			r = {1'b1, base + `CODE_OVERSPEED_OFS};
		else if (enc_checks && pos_dev_err)
			r = {1'b1, base + `CODE_POS_DEV_OFS};
		else if (enc_checks && pos_range_err)
			r = {1'b1, base + `CODE_POS_RANGE_OFS};
		else if (p.opt_fault)
			r = {1'b1, base + {4'h0, p.opt_code}}; // R7
		return r;
	endfunction : port_code

	// A process, not an assign: the function also reads the encoder check
	// nets, and a continuous assignment only wakes on its own arguments
	logic [8:0] op1_code, op2_code;
	always_comb begin
		op1_code = port_code(option_port_one_i, `CODE_OPT1_BASE,
			option_port_one_i.enc_open | ~option_port_two_i.enc_open);
		op2_code = port_code(option_port_two_i, `CODE_OPT2_BASE, 1'b0);
	end

	// Trip detection, by priority
	// Emergency comes first since it must act whatever else is wrong;
	// only the first cause latches, later ones wait for a clear
	logic [7:0] new_code;
	logic       new_trip, new_power_only;
	always_comb begin
		new_code       = `CODE_NONE;
		new_power_only = 1'b0;
		if (emr_en && emergency_stop_input)
			new_code = `CODE_EMERGENCY; // R2
		else if (brake_err)
			new_code = `CODE_BRAKE;
		else if (op1_code[8]) begin
			new_code       = op1_code[7:0];
			new_power_only = option_port_one_i.enc_board_fail;
		end else if (op2_code[8]) begin
			new_code       = op2_code[7:0];
			new_power_only = option_port_two_i.enc_board_fail;
		end else if (low_ovl_trip)
			new_code = `CODE_LOW_OVERLOAD;
		else if (link_timeout_i && ctrl_reg[`CTRL_TIMEOUT_TRIP])
			new_code = `CODE_LINK; // R6
		new_trip = new_code != `CODE_NONE;
	end

	// Trip latch and reset gating
	// The terminal acts on its rising edge, so a terminal held on cannot
	// clear a trip that appears after it was pressed
	logic [7:0] trip_code_reg;
	logic       power_only_reg, clear_ok, term_prev_reg, term_edge;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			term_prev_reg <= 1'b0;
		else
			term_prev_reg <= rst_term;
	end
	assign term_edge = rst_term && !term_prev_reg;
	// Only rst_i, the power-up reset, ever leaves a power-only trip
	always_comb begin
		if (power_only_reg)
			clear_ok = 1'b0; // R4
		else if (trip_code_reg == `CODE_EMERGENCY)
			clear_ok = term_edge && !(emr_en && emergency_stop_input); // R3
		else
			clear_ok = term_edge || panel_reset_i || sw_reset_pulse;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_code_reg  <= `CODE_NONE; // R4
			power_only_reg <= 1'b0;
		end else if (trip_code_reg == `CODE_NONE) begin
			if (new_trip) begin
				trip_code_reg  <= new_code; // R18
				power_only_reg <= new_power_only;
			end
		end else if (clear_ok) begin
			trip_code_reg  <= `CODE_NONE;
			power_only_reg <= 1'b0;
		end
	end

	// Outputs from flip-flops; emergency forces off without waiting
	logic run_limited;
	assign run_limited = (run_fwd_i && ctrl_reg[`CTRL_FWD_FORBID])
		|| (run_rev_i && ctrl_reg[`CTRL_REV_FORBID]); // R11
	// Gate drops at the edge that latches the trip, not one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i)
			power_enable_o <= 1'b0;
		else
			power_enable_o <= trip_code_reg == `CODE_NONE && !new_trip
				&& !uv && !poff; // R2
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			trip_code_o <= `CODE_NONE;
		else
			trip_code_o <= trip_code_reg; // R18
	end

	// Indications are plain levels that follow their causes, not latched
	always_ff @(posedge clk_i) begin
		if (rst_i)
			indication_o <= '0;
		else begin
			indication_o.undervoltage   <= uv; // R8
			indication_o.power_shutoff  <= poff; // R17
			indication_o.retry_standby  <= retry_wait_i
				&& ctrl_reg[`CTRL_RETRY_EN]; // R10
			indication_o.run_limited    <= run_limited;
			indication_o.panel_comm_err <= panel_fail_i; // R9
		end
	end

	// Sticky event bits; set wins over a clear in the same cycle
	logic [7:0] ev;
	logic [7:0] irq_clear;
	assign ev = {3'h0, run_limited, panel_fail_i, poff, uv,
		new_trip && trip_code_reg == `CODE_NONE};
	assign irq_clear = (bus_hit && wb_i.we && wb_i.adr == `OFS_IRQ_CLEAR)
		? wb_i.dat[7:0] : 8'h00;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_reg <= '0;
			irq_o          <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | ev;
			irq_o          <= |(irq_status_reg & irq_enable_reg);
		end
	end

	// Bus answer: one cycle after the request, unmapped reads give zero
	// Ack masks the request for one cycle only, so a request still held
	// is answered again every other cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_hit;
			wb_dat_o <= '0;
			if (bus_hit && !wb_i.we) begin
				unique case (wb_i.adr)
					`OFS_CTRL:       wb_dat_o <= ctrl_reg;
					`OFS_BRAKE_WAIT: wb_dat_o <= brake_wait_reg;
					`OFS_MAXFREQ:    wb_dat_o <= maxfreq_reg;
					`OFS_OVERSPEED:  wb_dat_o <= overspeed_reg;
					`OFS_FWD_LIMIT:  wb_dat_o <= fwd_limit_reg;
					`OFS_REV_LIMIT:  wb_dat_o <= rev_limit_reg;
					`OFS_TRIP:       wb_dat_o <= {23'h0, power_only_reg,
						trip_code_reg};
					`OFS_STATUS:     wb_dat_o <= {26'h0, power_enable_o,
						indication_o};
					`OFS_IRQ_STATUS: wb_dat_o <= {24'h0, irq_status_reg};
					`OFS_IRQ_ENABLE: wb_dat_o <= {24'h0, irq_enable_reg};
					default:         wb_dat_o <= '0;
				endcase
			end
		end
	end

endmodule : drive_trip_supervisor

// ==== verification/drive_trip_supervisor_sva.sv ====
// Checker for the drive trip supervisor, bound to its top ports.
// Assumes one clock domain and the synchronous active-high reset.
`include "trip_supervisor_consts.svh"
module trip_checker (
	input wire logic                         clk_i,      // Clock
	input wire logic                         rst_i,      // Reset
	input wire trip_supervisor_pkg::wb_req_t wb_i,       // Bus request
	input wire logic                         wb_ack_o,   // Ack
	input wire logic                         power_enable_o, // Gate
	input wire logic [7:0]                   trip_code_o, // Code
	input wire trip_supervisor_pkg::indication_t indication_o, // Flags
	input wire logic emergency_stop_input_i,    // Stop pin
	input wire logic emergency_enable_switch_i, // Stop enable
	input wire logic fault_reset_terminal_i,    // Reset pin
	input wire logic undervolt_i,               // Low supply
	input wire logic supply_off_i,              // Supply gone
	input wire logic panel_fail_i               // Panel fault
);
	import trip_supervisor_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_next: assert property (
		wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
		else $error("ack without request");
	a_trip_gate: assert property (
		trip_code_o != `CODE_NONE |-> !power_enable_o)
		else $error("output enabled while tripped");
	a_code_held: assert property (
		$past(trip_code_o) != `CODE_NONE |-> trip_code_o == `CODE_NONE
		|| trip_code_o == $past(trip_code_o))
		else $error("trip code replaced");
	a_estop_off: assert property (
		(emergency_stop_input_i && emergency_enable_switch_i) [*8]
		|-> !power_enable_o)
		else $error("output on during emergency stop");
	// Terminal low long enough that no synchronised edge is in flight
	a_estop_kept: assert property (
		(trip_code_o == `CODE_EMERGENCY && !fault_reset_terminal_i) [*8]
		|=> trip_code_o == `CODE_EMERGENCY)
		else $error("emergency trip cleared without terminal");
	a_board_kept: assert property (
		trip_code_o inside {8'h69, 8'h79} |=> $stable(trip_code_o))
		else $error("power-cycle trip cleared");
	a_supply_flag: assert property (
		supply_off_i [*8] |-> indication_o.power_shutoff)
		else $error("power shutoff not shown");
	a_uv_flag: assert property (
		undervolt_i [*8] |-> indication_o.undervoltage)
		else $error("undervoltage not shown");
	a_panel_flag: assert property (
		panel_fail_i [*3] |-> indication_o.panel_comm_err)
		else $error("panel error not shown");
endmodule : trip_checker

// ==== verification/brake_model.sv ====
// Brake partner: confirms the release command through its contact.
// Assumes the bench chooses a working or a seized brake per scenario.
module brake_model (
	input  wire logic clk_i,     // Clock
	input  wire logic release_i, // Release command
	input  wire logic stuck_i,   // Brake seized, never confirms
	output      logic feedback_o // Confirmation contact
);
	logic [1:0] dly_reg = 2'h0;
	// Contact lags the command like a real relay, so no instant answer
	always_ff @(posedge clk_i) begin
		dly_reg <= {dly_reg[0], release_i};
		feedback_o <= dly_reg[1] && !stuck_i;
	end
endmodule : brake_model

// ==== verification/tb_drive_trip_supervisor.sv ====
// Bench for the drive trip supervisor: bus tasks, pin stimulus and a
// monitor that checks each read against the oldest noted value.
// Assumes the design, checker and brake model are compiled first.
`include "trip_supervisor_consts.svh"
module tb_drive_trip_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	import trip_supervisor_pkg::*;
	typedef struct packed {
		logic estop, ensw, term, brel, ovl, lto, pfail;
		logic pkey, uv, soff, rwait, rfwd, rrev;
	} pins_t;
	pins_t              p = '0;
	port_fault_t        op [2] = '{'0, '0};
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	wb_req_t            wb_i = '0;
	logic [31:0]        wb_dat_o, spd = '0;
	logic signed [31:0] pos = '0, pref = '0;
	logic [15:0]        frq = '0;
	logic               wb_ack_o, irq_o, power_enable_o, fb, stuck = 1'b0;
	logic [7:0]         trip_code_o, base;
	logic [3:0]         k;
	indication_t        indication_o;
	logic [32:0]        notes [$];
	logic [32:0]        exp_v;
	int                 err_total = 0, tests_run = 0, cyc_n = 0;
	int                 seed = 10984;

	drive_trip_supervisor #(.TICK_CYCLES(4), .OVL_LIMIT(3)) u_dut (
		.clk_i, .rst_i, .wb_i, .wb_dat_o, .wb_ack_o, .irq_o,
		.emergency_stop_input_i(p.estop), .emergency_enable_switch_i(p.ensw),
		.fault_reset_terminal_i(p.term), .brake_release_i(p.brel),
		.brake_feedback_i(fb), .overload_i(p.ovl), .out_freq_i(frq),
		.link_timeout_i(p.lto), .panel_fail_i(p.pfail),
		.panel_reset_i(p.pkey), .undervolt_i(p.uv), .supply_off_i(p.soff),
		.retry_wait_i(p.rwait), .run_fwd_i(p.rfwd), .run_rev_i(p.rrev),
		.option_port_one_i(op[0]), .option_port_two_i(op[1]),
		.speed_i(spd), .pos_i(pos), .pos_ref_i(pref), .power_enable_o,
		.trip_code_o, .indication_o);
	brake_model u_brake (.clk_i, .release_i(p.brel), .stuck_i(stuck),
		.feedback_o(fb));

	always #20 clk_i = ~clk_i;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic bus(input logic [7:0] a, input logic [31:0] d,
		input logic w);
		wb_i <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, d, 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		notes.push_back(e);
		bus(a, 32'h0, 1'b0);
	endtask : rd

	task automatic settle(input logic [32:0] e);
		cyc(8);
		rd(`OFS_TRIP, e);
	endtask : settle

	function automatic logic [32:0] tr(input logic [7:0] c,
		input logic po = 1'b0);
		return {24'h0, po, c};
	endfunction : tr

	// Power cycle: the only way out of a board failure trip
	task automatic pwr;
		rst_i <= 1'b1;
		p <= '0;
		op <= '{'0, '0};
		{spd, pos, pref, frq, stuck} <= '0;
		cyc(2);
		rst_i <= 1'b0;
		cyc(1);
	endtask : pwr

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask : done

	task final_report;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	always @(posedge clk_i) begin
		cyc_n++;
		if (wb_ack_o === 1'b1 && wb_i.we === 1'b0) begin
			exp_v = notes.pop_front();
			tests_run++;
			if ({irq_o, wb_dat_o} !== exp_v) begin
				err_total++;
				$display("CHECK FAILED %0t: read %h, want %h", $time,
					{irq_o, wb_dat_o}, exp_v);
			end
		end
		if (cyc_n == 6000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		cyc(20);
		rst_i <= 1'b0;
		cyc(1);
		rd(`OFS_CTRL, 33'h0);
		rd(8'h3C, 33'h0);
		for (int s = 0; s < 2; s++) begin
			pwr();
			stuck <= s[0];
			wr(`OFS_CTRL, 32'h1);
			wr(`OFS_BRAKE_WAIT, 32'h5);
			p.brel <= 1'b1;
			cyc(40);
			rd(`OFS_TRIP, tr(s ? `CODE_BRAKE : 8'h0));
		end
		done("brake");
		pwr();
		p.estop <= 1'b1;
		settle(tr(8'h0));
		p.estop <= 1'b0;
		cyc(8);
		p.ensw <= 1'b1;
		p.estop <= 1'b1;
		settle(tr(`CODE_EMERGENCY));
		p.estop <= 1'b0;
		p.pkey <= 1'b1;
		cyc(1);
		p.pkey <= 1'b0;
		wr(`OFS_RESET_CMD, 32'h1);
		settle(tr(`CODE_EMERGENCY));
		p.term <= 1'b1;
		cyc(8);
		p.term <= 1'b0;
		settle(tr(8'h0));
		done("emergency");
		for (int i = 0; i < 2; i++) begin
			k = 4'h4 + 4'($random(seed) & 3);
			base = i ? `CODE_OPT2_BASE : `CODE_OPT1_BASE;
			pwr();
			op[i].enc_open <= 1'b1;
			settle(tr(base));
			pwr();
			op[i].opt_fault <= 1'b1;
			op[i].opt_code <= k;
			settle(tr(base + 8'(k)));
			pwr();
			op[i].enc_board_fail <= 1'b1;
			cyc(4);
			op[i] <= '0;
			p.term <= 1'b1;
			p.pkey <= 1'b1;
			cyc(1);
			p.pkey <= 1'b0;
			wr(`OFS_RESET_CMD, 32'h1);
			p.term <= 1'b0;
			settle(tr(base + 8'h9, 1'b1));
		end
		done("option ports");
		// Encoder checks are taken as reported under port one's codes
		pwr();
		wr(`OFS_MAXFREQ, 32'd100);
		wr(`OFS_OVERSPEED, 32'd110);
		spd <= 32'd110;
		settle(tr(8'h0));
		spd <= 32'd111;
		settle(tr(8'h61));
		pwr();
		wr(`OFS_CTRL, 32'h20);
		pos <= 32'sd1000000;
		settle(tr(8'h0));
		pos <= 32'sd1000001;
		settle(tr(8'h62));
		pwr();
		wr(`OFS_FWD_LIMIT, 32'd500);
		wr(`OFS_CTRL, 32'h60);
		{pos, pref} <= {32'sd500, 32'sd500};
		settle(tr(8'h0));
		{pos, pref} <= {32'sd501, 32'sd501};
		settle(tr(8'h63));
		done("encoder");
		pwr();
		{p.ovl, frq} <= {1'b1, 16'd21};
		cyc(30);
		rd(`OFS_TRIP, tr(8'h0));
		frq <= 16'd20;
		cyc(30);
		rd(`OFS_TRIP, tr(`CODE_LOW_OVERLOAD));
		pwr();
		for (int t = 0; t < 2; t++) begin
			wr(`OFS_CTRL, t ? 32'h4 : 32'h0);
			p.lto <= 1'b1;
			cyc(1);
			p.lto <= 1'b0;
			settle(tr(t ? `CODE_LINK : 8'h0));
		end
		done("overload and link");
		for (int d = 0; d < 2; d++) begin
			pwr();
			wr(`OFS_IRQ_ENABLE, 32'h10);
			wr(`OFS_CTRL, 32'h8 << d);
			{p.rrev, p.rfwd} <= 2'(1 << d);
			cyc(4);
			rd(`OFS_IRQ_STATUS, {1'b1, 32'h10});
			wr(`OFS_IRQ_ENABLE, 32'h0);
			rd(`OFS_IRQ_STATUS, {1'b0, 32'h10});
			{p.rrev, p.rfwd} <= 2'b0;
			wr(`OFS_IRQ_CLEAR, 32'h10);
			rd(`OFS_IRQ_STATUS, 33'h0);
		end
		p.rwait <= 1'b1;
		cyc(2);
		rd(`OFS_STATUS, 33'h20);
		wr(`OFS_CTRL, 32'h80);
		rd(`OFS_STATUS, 33'h24);
		{p.uv, p.soff, p.pfail} <= 3'b111;
		cyc(10);
		rd(`OFS_IRQ_STATUS, 33'h0E);
		rd(`OFS_STATUS, 33'h1D);
		done("indications");
		final_report();
	end
endmodule : tb_drive_trip_supervisor

bind drive_trip_supervisor trip_checker u_chk (
	.clk_i, .rst_i, .wb_i, .wb_ack_o, .power_enable_o, .trip_code_o,
	.indication_o, .emergency_stop_input_i, .emergency_enable_switch_i,
	.fault_reset_terminal_i, .undervolt_i, .supply_off_i, .panel_fail_i);
